// *** bench/ext_irq_pin_and_vector_logic_bench.sv ***
/* self-checking bench for the pin interrupt and vector block.
   assumes irq_pkg, the bound checker and irq_source_model. */
`timescale 1ns/1ns
module ext_irq_pin_and_vector_logic_bench
  import irq_pkg::*;
;
  localparam logic [7:0] ctl_a = pin_irq_status_control_off;
  logic aclk = 1'h0, aresetn = 1'h0, stop_mode = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, soft_irq_exec = 1'h0;
  logic low_voltage_event = 1'h0, periodic_wake_event = 1'h0;
  logic drive_en = 1'h1, drive_val = 1'h0;
  logic [5:0] reset_causes = 6'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_pin, pull_up_en, pull_down_en, cpu_irq_req;
  logic wake_out, mask_bit, irq_out;
  logic [4:0] vector_num;
  logic [15:0] vector_addr;
  logic [2:0] stack_count;
  int err_count = 0, checks_done = 0, seed = 24435;
  int exp_q[$];
  pin_irq_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_pin, .pull_up_en,
    .pull_down_en, .soft_irq_exec, .low_voltage_event, .periodic_wake_event,
    .reset_causes, .stop_mode, .cpu_irq_req, .wake_out, .vector_num,
    .vector_addr, .stack_count, .mask_bit, .irq_out);
  irq_source_model src_u (.aclk, .drive_en, .drive_val, .pull_up_en,
    .pull_down_en, .pin(irq_pin));
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_rd
  task automatic pin_case(input logic [2:0] i);
    logic [31:0] c;
    c = {26'h0, i[0], 3'h5, i[2], i[1]};
    drive_val <= ~i[0];
    axi_wr(ctl_a, c);
    cyc(6);
    axi_rd(int_status_off);
    drive_val <= i[0];
    cyc(8);
    axi_rd(ctl_a);
    chk(rv[3], 1'h1);
    chk(rv[7], i[0]);
    chk(cpu_irq_req, i[2]);
    chk(irq_out, 1'h1);
    axi_wr(ctl_a, c);
    axi_rd(ctl_a);
    chk(rv[3], i[1]);
    drive_val <= ~i[0];
    cyc(8);
    axi_wr(ctl_a, c);
    axi_rd(ctl_a);
    chk(rv[3], 1'h0);
    axi_rd(int_status_off);
    chk(rv[0], 1'h1);
    cyc(2);
    chk(irq_out, 1'h0);
  endtask : pin_case
  task automatic take();
    int v;
    v = exp_q.pop_front();
    axi_wr(cpu_ctrl_off, 32'h0);
    while (mask_bit !== 1'h1)
      @(posedge aclk);
    cyc(2);
    chk(vector_num, v);
    chk(vector_addr, 32'hfffe - 2 * v);
    axi_wr(src_flag_off, 32'h1 << v);
    // pin flag is acked only once its own vector has been served
    if (v == vec_pin)
      axi_wr(ctl_a, 32'h36);
  endtask : take
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_rd(cpu_ctrl_off);
    chk(rv[0], 1'h1);
    axi_rd(ctl_a);
    chk(rv[7:0], ctl_reset);
    axi_rd(8'h1c);
    chk(rr, axi_slverr);
    axi_wr(8'h1c, $random(seed));
    chk(rr, axi_slverr);
    for (int i = 0; i < 8; i++)
    begin
      axi_wr(ctl_a, {25'h0, i[2:0], 4'h0});
      cyc(2);
      chk({pull_up_en, pull_down_en},
        {i[0] & ~i[2] & ~i[1], i[0] & ~i[2] & i[1]});
    end
    axi_wr(ctl_a, 32'h4);
    drive_en <= 1'h0;
    cyc(12);
    drive_en <= 1'h1;
    axi_rd(ctl_a);
    chk(rv[3], 1'h0);
    axi_wr(int_mask_off, 32'h1);
    for (int i = 0; i < 8; i++)
      pin_case(i[2:0]);
    axi_wr(int_mask_off, 32'h0);
    drive_val <= 1'h0;
    cyc(8);
    axi_rd(int_status_off);
    drive_val <= 1'h1;
    cyc(8);
    chk(irq_out, 1'h0);
    axi_rd(int_status_off);
    chk(rv[0], 1'h1);
    stop_mode <= 1'h1;
    cyc(4);
    chk(wake_out, 1'h1);
    drive_val <= 1'h0;
    cyc(4);
    chk(wake_out, 1'h0);
    stop_mode <= 1'h0;
    axi_wr(src_enable_off, 32'h0080_0004);
    axi_wr(ctl_a, 32'h36);
    drive_val <= 1'h1;
    low_voltage_event <= 1'h1;
    periodic_wake_event <= 1'h1;
    @(posedge aclk);
    low_voltage_event <= 1'h0;
    periodic_wake_event <= 1'h0;
    exp_q = {2, 3, 23, 1, 0, 0, 0, 0, 0, 0};
    cyc(8);
    repeat (3) take();
    for (int i = 0; i < 7; i++)
    begin
      if (i == 0)
        soft_irq_exec <= 1'h1;
      else
        reset_causes <= 6'h01 << (i - 1);
      @(posedge aclk);
      soft_irq_exec <= 1'h0;
      reset_causes <= 6'h00;
      cyc(2);
      take();
    end
    give_verdict();
  end
endmodule : ext_irq_pin_and_vector_logic_bench

// *** bench/irq_source_model.sv ***
/* external device on the request pin.
   assumes the pull enables come from the block. */
`timescale 1ns/1ns
module irq_source_model
(
  // clock
  input wire logic aclk,
  // bench drive
  input wire logic drive_en,
  input wire logic drive_val,
  // pull devices
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // pin
  output logic pin
);
  logic float_reg = 1'h0;
  // undriven, unpulled pin wanders each cycle
  always @(posedge aclk)
    float_reg <= ~float_reg;
  assign pin = drive_en ? drive_val : pull_up_en ? 1'h1 :
    pull_down_en ? 1'h0 : float_reg;
endmodule : irq_source_model

// *** bench/pin_irq_ctrl_checker.sv ***
/* port checker for pin_irq_ctrl.
   assumes it is bound onto the block by the bind below. */
`timescale 1ns/1ns
module pin_irq_ctrl_checker
  import irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin and cpu side
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  input wire logic stop_mode,
  input wire logic wake_out,
  input wire logic [15:0] vector_addr,
  input wire logic [4:0] vector_num,
  input wire logic [2:0] stack_count,
  input wire logic mask_bit
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_stack_end;
    ##3 stack_count == 3'h4 ##1 (stack_count == 3'h5 && mask_bit);
  endsequence
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    |=> s_axi_bvalid && s_axi_awready) else $error("no write answer");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_answer: assert property (
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid && s_axi_arready)
    else $error("no read answer");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_pull_exclusive: assert property (
    !(pull_up_en && pull_down_en)) else $error("both pulls on");
  a_wake_stop: assert property (
    wake_out |-> $past(stop_mode)) else $error("wake outside stop");
  a_vector_addr: assert property (
    vector_addr != 16'h0000
    |-> vector_addr == vector_top - {10'h000, vector_num, 1'h0})
    else $error("vector address wrong");
  a_stack_entry: assert property (
    stack_count == 3'h1 |-> s_stack_end)
    else $error("stacking did not end with mask set");
endmodule : pin_irq_ctrl_checker

bind pin_irq_ctrl pin_irq_ctrl_checker chk_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pull_up_en, .pull_down_en, .stop_mode,
  .wake_out, .vector_addr, .vector_num, .stack_count, .mask_bit);

// *** src/irq_pkg.sv ***
/*
  constants, register map and carrier types for the pin interrupt
  and vector priority block. assumes a 32-bit axi4-lite register bus.
*/
package irq_pkg;
  // register byte offsets
  localparam logic [7:0] pin_irq_status_control_off = 8'h00;
  localparam logic [7:0] src_flag_off = 8'h04;
  localparam logic [7:0] src_enable_off = 8'h08;
  localparam logic [7:0] int_status_off = 8'h0c;
  localparam logic [7:0] int_mask_off = 8'h10;
  localparam logic [7:0] vector_off = 8'h14;
  localparam logic [7:0] cpu_ctrl_off = 8'h18;
  // pin_irq_status_control field positions
  localparam int ctl_mode_bit = 0;
  localparam int ctl_ie_bit = 1;
  localparam int ctl_ack_bit = 2;
  localparam int ctl_flag_bit = 3;
  localparam int ctl_pe_bit = 4;
  localparam int ctl_edg_bit = 5;
  localparam int ctl_pdd_bit = 6;
  localparam int ctl_level_bit = 7;
  localparam logic [7:0] ctl_reset = 8'h00;
  // vector numbers
  localparam logic [4:0] vec_reset = 5'h00;
  localparam logic [4:0] vec_soft = 5'h01;
  localparam logic [4:0] vec_lvd = 5'h02;
  localparam logic [4:0] vec_pin = 5'h03;
  localparam logic [4:0] vec_rti = 5'h17;
  localparam int num_vectors = 32;
  localparam logic [15:0] vector_top = 16'hfffe;
  // reset cause bits
  localparam int rst_cop = 0;
  localparam int rst_lvd = 1;
  localparam int rst_pin = 2;
  localparam int rst_ilop = 3;
  localparam int rst_ilad = 4;
  localparam int rst_por = 5;
  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;
  // event status bits
  localparam int ev_pin = 0;
  localparam int ev_vector = 1;
  localparam int ev_wake = 2;

  typedef struct packed {
    logic pdd;
    logic edg;
    logic pe;
    logic ie;
    logic mode;
  } pin_ctl_t;

  typedef struct packed {
    logic valid;
    logic [4:0] num;
    logic [15:0] addr_hi;
    logic [15:0] addr_lo;
  } vector_t;

  typedef enum logic [2:0] {
    cpu_run = 3'b001,
    cpu_stack = 3'b010,
    cpu_fetch = 3'b100
  } cpu_state_t;
endpackage : irq_pkg

// *** src/pin_irq_ctrl.sv ***
/*
  external request pin logic, source flags, interrupt vector choice
  and cpu entry sequencing, with an axi4-lite register slave.
  assumes one bus clock, pin asynchronous, stop handled by the stop
  input gating clocks elsewhere.
*/
`timescale 1ns/1ns
// Summary of operation
// R1: pin acts as request input only while the function enable is one.
// R2: polarity bit selects falling/low or rising/high as the asserted sense.
// R3: mode bit picks edge-only or edge-and-level detection.
// R4: local enable decides interrupt request versus polled flag only.
// R5: pull device on when enabled and not disabled, pullup or pulldown.
// R6: writing one to pull disable turns the internal pull device off.
// R7: in stop, an asynchronous path sees the pin event and wakes the chip.
// R8: flag sets on assert edge; level mode keeps it set while asserted.
// R9: pin level readable for branch-on-pin tests when configured.
// R10: each source flag sets on event; request forwarded only if enabled, except software and reset, which are always forwarded.
// R11: with mask clear, stack pc low, pc high, x, a, condition codes, fetch.
// R12: vector address read high byte first, low byte at next address.
// R13: lower vector number wins; unused 24 to 31 lowest.
// R14: pin 3, low voltage 2, software 1, periodic wake 23.
// R15: all reset causes use vector 0 at the top of memory.
// R16: polarity zero is falling/low, one is rising/high.
// R17: pin synchronised before edge detection, one set per edge.
module pin_irq_ctrl
  import irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request pin and pull device
  input wire logic irq_pin,
  output logic pull_up_en,
  output logic pull_down_en,
  // other sources
  input wire logic soft_irq_exec,
  input wire logic low_voltage_event,
  input wire logic periodic_wake_event,
  input wire logic [5:0] reset_causes,
  input wire logic stop_mode,
  // cpu side
  output logic cpu_irq_req,
  output logic wake_out,
  output logic [4:0] vector_num,
  output logic [15:0] vector_addr,
  output logic [2:0] stack_count,
  output logic mask_bit,
  output logic irq_out
);
  typedef struct packed {
    pin_ctl_t ctl;
    logic flag;
    logic lvl_d;
    logic soft_flag;
    logic lvd_flag;
    logic lvd_ie;
    logic rti_flag;
    logic rti_ie;
    logic rst_flag;
    logic ibit;
    cpu_state_t cst;
    logic [2:0] scnt;
    logic [4:0] vnum;
    logic [15:0] vaddr;
    logic req;
    logic wake;
    logic pu;
    logic pd;
    logic [2:0] ev_stat;
    logic [2:0] ev_mask;
    logic irq;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  logic pin_level;
  logic [num_vectors-1:0] pending;
  vector_t winner;
  logic asserted;
  logic async_hit;
  logic wr_go;
  logic rd_go;
  logic [7:0] ctl_rd;

  pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(irq_pin),
    .level(pin_level)
  );

  // asserted sense after polarity
  assign asserted = state_reg.ctl.edg ? pin_level : ~pin_level; // see R16
  // asynchronous wake path, combinational on the raw pin
  assign async_hit = stop_mode & state_reg.ctl.pe
    & (state_reg.ctl.edg ? irq_pin : ~irq_pin); // see R7

  always_comb
  begin
    pending = '0;
    pending[vec_reset] = state_reg.rst_flag; // see R15
    pending[vec_soft] = state_reg.soft_flag; // see R14
    pending[vec_lvd] = state_reg.lvd_flag & state_reg.lvd_ie; // see R10
    pending[vec_pin] = state_reg.flag & state_reg.ctl.ie; // see R4
    pending[vec_rti] = state_reg.rti_flag & state_reg.rti_ie; // see R10
  end

  vector_prio u_prio (
    .pending(pending),
    .winner(winner)
  );

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~state_reg.bv;
  assign rd_go = s_axi_arvalid & ~state_reg.rv;

  always_comb
  begin
    ctl_rd = ctl_reset;
    ctl_rd[ctl_mode_bit] = state_reg.ctl.mode;
    ctl_rd[ctl_ie_bit] = state_reg.ctl.ie;
    ctl_rd[ctl_flag_bit] = state_reg.flag;
    ctl_rd[ctl_pe_bit] = state_reg.ctl.pe;
    ctl_rd[ctl_edg_bit] = state_reg.ctl.edg;
    ctl_rd[ctl_pdd_bit] = state_reg.ctl.pdd;
    // level visible for branch-on-pin only when configured
    ctl_rd[ctl_level_bit] = state_reg.ctl.pe & pin_level; // see R9
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.lvl_d = asserted;
    state_next.awr = 1'b0;
    state_next.wr = 1'b0;
    state_next.arr = 1'b0;
    // bus handshakes
    if (state_reg.bv && s_axi_bready)
    begin
      state_next.bv = 1'b0;
    end
    if (state_reg.rv && s_axi_rready)
    begin
      state_next.rv = 1'b0;
    end
    // source flags: writes clear first, events set after and win
    if (wr_go)
    begin
      state_next.awr = 1'b1;
      state_next.wr = 1'b1;
      state_next.bv = 1'b1;
      state_next.br = axi_okay;
      unique case (s_axi_awaddr)
        pin_irq_status_control_off:
        begin
          if (s_axi_wstrb[0])
          begin
            state_next.ctl.mode = s_axi_wdata[ctl_mode_bit]; // see R3
            state_next.ctl.ie = s_axi_wdata[ctl_ie_bit]; // see R4
            state_next.ctl.pe = s_axi_wdata[ctl_pe_bit]; // see R1
            state_next.ctl.edg = s_axi_wdata[ctl_edg_bit]; // see R2
            state_next.ctl.pdd = s_axi_wdata[ctl_pdd_bit]; // see R6
            if (s_axi_wdata[ctl_ack_bit])
            begin
              state_next.flag = 1'b0;
            end
          end
        end
        src_flag_off:
        begin
          if (s_axi_wstrb[0])
          begin
            if (s_axi_wdata[vec_soft]) state_next.soft_flag = 1'b0;
            if (s_axi_wdata[vec_lvd]) state_next.lvd_flag = 1'b0;
            if (s_axi_wdata[0]) state_next.rst_flag = 1'b0;
          end
          if (s_axi_wstrb[2] && s_axi_wdata[vec_rti])
          begin
            state_next.rti_flag = 1'b0;
          end
        end
        src_enable_off:
        begin
          if (s_axi_wstrb[0])
          begin
            state_next.lvd_ie = s_axi_wdata[vec_lvd];
          end
          if (s_axi_wstrb[2])
          begin
            state_next.rti_ie = s_axi_wdata[vec_rti];
          end
        end
        int_mask_off:
        begin
          if (s_axi_wstrb[0])
          begin
            state_next.ev_mask = s_axi_wdata[2:0];
          end
        end
        cpu_ctrl_off:
        begin
          if (s_axi_wstrb[0])
          begin
            state_next.ibit = s_axi_wdata[0];
          end
        end
        default:
        begin
          state_next.br = axi_slverr;
        end
      endcase
    end
    if (rd_go)
    begin
      state_next.arr = 1'b1;
      state_next.rv = 1'b1;
      state_next.rr = axi_okay;
      state_next.rd = '0;
      unique case (s_axi_araddr)
        pin_irq_status_control_off: state_next.rd[7:0] = ctl_rd;
        src_flag_off:
        begin
          state_next.rd[vec_reset] = state_reg.rst_flag;
          state_next.rd[vec_soft] = state_reg.soft_flag;
          state_next.rd[vec_lvd] = state_reg.lvd_flag;
          state_next.rd[vec_pin] = state_reg.flag;
          state_next.rd[vec_rti] = state_reg.rti_flag;
        end
        src_enable_off:
        begin
          state_next.rd[vec_lvd] = state_reg.lvd_ie;
          state_next.rd[vec_pin] = state_reg.ctl.ie;
          state_next.rd[vec_rti] = state_reg.rti_ie;
        end
        int_status_off:
        begin
          state_next.rd[2:0] = state_reg.ev_stat;
          state_next.ev_stat = '0;
        end
        int_mask_off: state_next.rd[2:0] = state_reg.ev_mask;
        vector_off:
        begin
          state_next.rd[4:0] = state_reg.vnum;
          state_next.rd[31:16] = state_reg.vaddr;
        end
        cpu_ctrl_off:
        begin
          state_next.rd[0] = state_reg.ibit;
          state_next.rd[10:8] = state_reg.scnt;
        end
        default: state_next.rr = axi_slverr;
      endcase
    end
    // pin detection in run mode
    if (state_reg.ctl.pe && asserted && !state_reg.lvl_d)
    begin
      state_next.flag = 1'b1; // see R8
      state_next.ev_stat[ev_pin] = 1'b1;
    end
    if (state_reg.ctl.pe && state_reg.ctl.mode && asserted)
    begin
      state_next.flag = 1'b1; // see R8
    end
    if (!state_reg.ctl.pe)
    begin
      state_next.flag = 1'b0; // see R1
    end
    if (soft_irq_exec) state_next.soft_flag = 1'b1; // see R14
    if (low_voltage_event) state_next.lvd_flag = 1'b1; // see R10
    if (periodic_wake_event) state_next.rti_flag = 1'b1; // see R10
    if (|reset_causes)
    begin
      state_next.rst_flag = 1'b1; // see R15
    end
    // pull device
    state_next.pu = state_reg.ctl.pe & ~state_reg.ctl.pdd
      & ~state_reg.ctl.edg; // see R5
    state_next.pd = state_reg.ctl.pe & ~state_reg.ctl.pdd
      & state_reg.ctl.edg; // see R5
    state_next.req = state_reg.flag & state_reg.ctl.ie; // see R4
    state_next.wake = async_hit; // see R7
    if (async_hit)
    begin
      state_next.ev_stat[ev_wake] = 1'b1;
    end
    // cpu entry sequence
    unique case (state_reg.cst)
      cpu_run:
      begin
        if (winner.valid && (!state_reg.ibit
            || winner.num == vec_reset))
        begin
          state_next.cst = cpu_stack; // see R11
          state_next.scnt = 3'h0;
        end
      end
      cpu_stack:
      begin
        // pc low, pc high, x, a, ccr
        state_next.scnt = state_reg.scnt + 3'h1; // see R11
        if (state_reg.scnt == 3'h4)
        begin
          state_next.cst = cpu_fetch;
          state_next.ibit = 1'b1; // see R11
        end
      end
      cpu_fetch:
      begin
        state_next.vnum = winner.num; // see R13
        state_next.vaddr = winner.addr_hi; // see R12
        state_next.ev_stat[ev_vector] = 1'b1;
        state_next.cst = cpu_run;
      end
    endcase
    state_next.irq = |(state_next.ev_stat & state_reg.ev_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.ibit <= 1'b1;
      state_reg.cst <= cpu_run;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awr;
  assign s_axi_wready = state_reg.wr;
  assign s_axi_bvalid = state_reg.bv;
  assign s_axi_bresp = state_reg.br;
  assign s_axi_arready = state_reg.arr;
  assign s_axi_rvalid = state_reg.rv;
  assign s_axi_rdata = state_reg.rd;
  assign s_axi_rresp = state_reg.rr;
  assign pull_up_en = state_reg.pu;
  assign pull_down_en = state_reg.pd;
  assign cpu_irq_req = state_reg.req;
  assign wake_out = state_reg.wake;
  assign vector_num = state_reg.vnum;
  assign vector_addr = state_reg.vaddr;
  assign stack_count = state_reg.scnt;
  assign mask_bit = state_reg.ibit;
  assign irq_out = state_reg.irq;
endmodule : pin_irq_ctrl

// *** src/pin_sync.sv ***
/*
  three flop synchroniser for the request pin with agreement filter.
  assumes the pin is asynchronous to aclk.
*/
`timescale 1ns/1ns
module pin_sync
  import irq_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin in, filtered level out
  input wire logic pin_in,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;
  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = pin_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // change counts once stages two and three agree
    if (state_reg.s2 == state_reg.s3)
    begin
      state_next.lvl = state_reg.s3; // see R17
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.lvl;
endmodule : pin_sync

// *** src/vector_prio.sv ***
/*
  fixed priority encoder over pending vector requests, lower number
  wins. assumes requests are already gated by local enables.
*/
`timescale 1ns/1ns
module vector_prio
  import irq_pkg::*;
(
  // pending requests
  input wire logic [num_vectors-1:0] pending,
  // winner
  output vector_t winner
);
  always_comb
  begin
    winner = '0;
    for (int i = num_vectors - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        winner.valid = 1'b1;
        winner.num = 5'(i); // see R13
      end
    end
    // two bytes per vector, high byte first
    winner.addr_hi = vector_top - {10'h000, winner.num, 1'b0}; // see R12
    winner.addr_lo = winner.addr_hi + 16'h0001; // see R12
  end
endmodule : vector_prio
